// file: verif/tb.sv
// Self-checking testbench for the software watchdog timer.
module tb;
   import wdt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock;
   logic        reset;
   ctrl_wr_t    ctrl_wr;
   ctrl_rd_t    ctrl_rd;
   logic [15:0] reset_pc;
   int          error_cnt;
   int          checks;
   int          k;
   logic        seen;

   software_watchdog_timer software_watchdog_timer_i (
      .CLOCK    (clock),
      .RESET    (reset),
      .CTRL_WR  (ctrl_wr),
      .CTRL_RD  (ctrl_rd),
      .RESET_PC (reset_pc)
   );

   // Clock at 200 MHz.
   always #2.5 clock = ~clock;

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Comparisons, one for each kind of result.
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t register image %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cmp_cnt(input int got, input int exp);
      checks++;
      if (got != exp) begin
         error_cnt++;
         $display("ERROR %0t event at cycle %0d expected %0d", $time, got, exp);
      end
   endtask

   // One control register write, driven at the falling edge for one cycle.
   // An edge passes with the strobe low, so two writes in a row never meet in one time step.
   task automatic wr(input logic [1:0] s, input logic ie, re, rs, ci, cw);
      ctrl_wr = '{1'b1, s, ie, re, rs, ci, cw};
      @(negedge clock);
      ctrl_wr.wr = 1'b0;
      @(negedge clock);
   endtask

   // Counts cycles until a read-back bit goes high; a spent bound ends the run.
   task automatic count_to(input int idx, input int bound, inout int n);
      while (ctrl_rd[idx] !== 1'b1) begin
         if (n >= bound) begin
            error_cnt++;
            $display("ERROR %0t wait ran out", $time);
            summarize();
         end
         @(negedge clock);
         n++;
      end
   endtask

   // Restart with a new interval, then time the warning and the reset.
   task automatic timeout_run(input logic [1:0] s, input logic ie, re);
      int n;
      int i;
      n = 1 << (EXP_2P12 + 3 * s);
      k = 1; // Edges since the restart edge once the write task returns.
      wr(s, ie, re, 1'b1, 1'b1, 1'b1);
      count_to(4, n, k);
      cmp_cnt(k, n - WARN_LEAD);
      cmp_bit(ctrl_rd.irq, ie);
      if (re) begin
         count_to(0, n + 8, k);
         cmp_cnt(k, n);
         cmp_bit(ctrl_rd.reg_value[BIT_WRF], 1'b1);
         for (i = 0; i < RST_PULSE_LEN; i++) begin
            cmp_bit(ctrl_rd.sys_reset, 1'b1);
            @(negedge clock);
         end
         cmp_bit(ctrl_rd.sys_reset, 1'b0);
      end else begin
         seen = 1'b0;
         repeat (WARN_LEAD + 8) begin
            @(negedge clock);
            seen = seen | ctrl_rd.sys_reset;
         end
         cmp_bit(seen, 1'b0);
         cmp_bit(ctrl_rd.reg_value[BIT_IRQ_FLAG], 1'b1);
      end
   endtask

   // Main sequence; the long intervals are too slow to time in full, so only codes 0 and 1 are timed.
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      ctrl_wr = '0;
      error_cnt = 0;
      checks = 0;
      repeat (4) @(negedge clock);
      reset = 1'b0;
      cmp_reg(ctrl_rd.reg_value, CTRL_RESET);
      cmp_reg(reset_pc[15:8], RESET_VECTOR[15:8]);
      cmp_reg(reset_pc[7:0], RESET_VECTOR[7:0]);
      for (int s = 0; s < 4; s++) begin
         wr(s[1:0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         cmp_reg(ctrl_rd.reg_value, {1'b0, s[1:0], 5'h08});
      end
      timeout_run(2'h0, 1'b1, 1'b1);
      wr(2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
      cmp_reg(ctrl_rd.reg_value, 8'h0A);
      timeout_run(2'h1, 1'b0, 1'b0);
      // Regular restarts keep the warning away.
      wr(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      repeat (3) begin
         repeat (3000) @(negedge clock);
         wr(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      end
      cmp_reg(ctrl_rd.reg_value, 8'h02);
      cmp_bit(ctrl_rd.sys_reset, 1'b0);
      wr(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      reset = 1'b1;
      @(negedge clock);
      reset = 1'b0;
      cmp_reg(ctrl_rd.reg_value, CTRL_RESET);
      summarize();
   end
endmodule // tb

// file: verilog/software_watchdog_timer.sv
// Software watchdog timer: free-running counter, early warning and system reset.
//
// Function
// - Free-running counter advances every clock; software restart returns it to zero.
// - Missing restart before the selected timeout produces a full system reset.
// - Optional early warning interrupt, enabled by software.
// - Four selectable timeouts from 2^12 up to 2^21 system clocks.
// - Interrupt asserts exactly 512 system clocks before the reset.
// - Timeout counts system clocks, so duration follows the clock divide mode.
// - All control sits in one software watchdog control register.
// - Watchdog reset sets a readable reset flag in the control register.
// - After a watchdog reset execution resumes at location 8000h.
// - Interrupt flag sets even when disabled; software clears it.
module software_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int RST_PULSE = RST_PULSE_LEN
)
(
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire ctrl_wr_t    CTRL_WR,
   output ctrl_rd_t         CTRL_RD,
   output logic [15:0]      RESET_PC
);

   // Control fields, the free-running count, the reset pulse length and the compare results.
   logic [1:0]       sel_q, sel_d;
   logic             irq_en_q, irq_en_d;
   logic             rst_en_q, rst_en_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [2:0]       rpls_q, rpls_d;
   logic [CNT_W-1:0] limit;
   logic             warn_hit;
   logic             tmo_hit;
   logic             restart;
   logic             irq_flag;
   logic             wrf_flag;
   logic             sys_rst;

   // Timeout length from the select field.
   // Changing the select without a restart can step past the compare; the count then runs on to
   // its own wrap at 2^22 before the next timeout, so software should restart with a new select.
   always_comb begin
      unique case (sel_q)
         SEL_2P12: limit = CNT_W'(1) << EXP_2P12;
         SEL_2P15: limit = CNT_W'(1) << EXP_2P15;
         SEL_2P18: limit = CNT_W'(1) << EXP_2P18;
         SEL_2P21: limit = CNT_W'(1) << EXP_2P21;
      endcase
   end

   assign restart  = CTRL_WR.wr && CTRL_WR.restart;
   // Counts stay in system clocks, so a slower clock stretches the timeout.
   assign warn_hit = (cnt_q == limit - CNT_W'(WARN_LEAD + 1));
   assign tmo_hit  = (cnt_q == limit - CNT_W'(1));

   // Control fields and the counter; the timeout also restarts the count.
   always_comb begin
      sel_d    = sel_q;
      irq_en_d = irq_en_q;
      rst_en_d = rst_en_q;
      cnt_d    = cnt_q + CNT_W'(1);
      if (CTRL_WR.wr) begin
         sel_d    = CTRL_WR.sel;
         irq_en_d = CTRL_WR.irq_en;
         rst_en_d = CTRL_WR.rst_en;
      end
      if (restart || tmo_hit) begin
         cnt_d = '0;
      end
   end

   // Register the control fields and counter.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         sel_q    <= SEL_2P12;
         irq_en_q <= 1'b0;
         rst_en_q <= 1'b0;
         cnt_q    <= '0;
      end else begin
         sel_q    <= sel_d;
         irq_en_q <= irq_en_d;
         rst_en_q <= rst_en_d;
         cnt_q    <= cnt_d;
      end
   end

   // Reset pulse is a few clocks long so the whole core sees it.
   // The pulse length must stay below 8 to fit the three-bit pulse counter.
   always_comb begin
      rpls_d = (rpls_q != 3'h0) ? rpls_q - 3'h1 : 3'h0;
      if (tmo_hit && rst_en_q) begin
         rpls_d = 3'(RST_PULSE);
      end
   end

   // Register the reset pulse counter.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         rpls_q <= 3'h0;
      end else begin
         rpls_q <= rpls_d;
      end
   end

   assign sys_rst = (rpls_q != 3'h0);

   // Interrupt flag sets regardless of the enable.
   wdt_stage u_irq_flag (
      .CLOCK  (CLOCK),
      .RESET  (RESET),
      .set    (warn_hit),
      .clr    (CTRL_WR.wr && CTRL_WR.clr_irq),
      .flag_q (irq_flag)
   );

   // Reset flag survives the watchdog reset; only RESET or software clears it.
   wdt_stage u_wrf_flag (
      .CLOCK  (CLOCK),
      .RESET  (RESET),
      .set    (tmo_hit && rst_en_q),
      .clr    (CTRL_WR.wr && CTRL_WR.clr_wrf),
      .flag_q (wrf_flag)
   );

   // Read back the register image and drive the outputs.
   // Bit 0 is a write-1 action and always reads back as zero; bit 7 is unused.
   always_comb begin
      CTRL_RD                        = '0;
      CTRL_RD.reg_value[POS_SEL+:2]  = sel_q;
      CTRL_RD.reg_value[BIT_RST_EN]  = rst_en_q;
      CTRL_RD.reg_value[BIT_IRQ_FLAG]= irq_flag;
      CTRL_RD.reg_value[BIT_IRQ_EN]  = irq_en_q;
      CTRL_RD.reg_value[BIT_WRF]     = wrf_flag;
      CTRL_RD.irq                    = irq_flag && irq_en_q;
      CTRL_RD.sys_reset              = sys_rst;
   end

   // Fixed restart location that the core loads when a watchdog reset ends.
   assign RESET_PC = RESET_VECTOR;

   // Assertions. They run on the system clock and are quiet while RESET is high.
   // The lead checks look back from the timeout and forward from the warning instead of
   // waiting a fixed delay, so a restart inside the warning window is not taken as a failure;
   // software is allowed to rescue the system there.
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   sequence warn_s;
      warn_hit;
   endsequence

   sequence pulse_s;
      CTRL_RD.sys_reset [*4];
   endsequence

   // Upper bound of the warning window, local so that the delay range can name it.
   localparam int LEAD_SPAN = WARN_LEAD;

   reset_lead_a: assert property (tmo_hit |-> $past(warn_hit, WARN_LEAD))
      else $error("timeout not 512 clocks after warning");
   irq_flag_set_a: assert property (warn_hit |=> irq_flag)
      else $error("interrupt flag not set by warning");
   irq_gate_a: assert property (CTRL_RD.irq |-> irq_en_q && irq_flag)
      else $error("interrupt out without enable");
   rst_pulse_a: assert property (tmo_hit && rst_en_q |=> pulse_s)
      else $error("system reset pulse too short");
   no_rst_a: assert property (!rst_en_q && !sys_rst |=> !CTRL_RD.sys_reset)
      else $error("reset issued while disabled");
   restart_zero_a: assert property (restart |=> cnt_q == '0)
      else $error("restart did not clear counter");
   count_up_a: assert property (!restart && !tmo_hit |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("counter did not advance");
   wrf_set_a: assert property (tmo_hit && rst_en_q |=> CTRL_RD.reg_value[BIT_WRF])
      else $error("reset flag not set");
   short_tmo_a: assert property (sel_q == SEL_2P12 && tmo_hit |-> cnt_q == 22'h00_0FFF)
      else $error("shortest timeout wrong");
   sel_write_a: assert property (CTRL_WR.wr |=> sel_q == $past(CTRL_WR.sel))
      else $error("select not written");
   vector_a: assert property (RESET_PC == 16'h8000)
      else $error("reset vector wrong");

   // After a warning the count either reaches its timeout within the lead or is restarted.
   lead_bound_a: assert property (warn_s |-> ##[1:LEAD_SPAN] (tmo_hit || restart))
      else $error("no timeout within the warning lead");
   // The timeout itself starts the next period from zero.
   wrap_zero_a: assert property (tmo_hit |=> cnt_q == '0)
      else $error("counter not cleared at timeout");

   // Both flags hold until software clears them, and a clear with no new event takes effect.
   irq_hold_a: assert property (irq_flag && !(CTRL_WR.wr && CTRL_WR.clr_irq) |=> irq_flag)
      else $error("interrupt flag dropped without a clear");
   irq_clear_a: assert property (CTRL_WR.wr && CTRL_WR.clr_irq && !warn_hit |=> !irq_flag)
      else $error("interrupt flag not cleared");
   wrf_hold_a: assert property (wrf_flag && !(CTRL_WR.wr && CTRL_WR.clr_wrf) |=> wrf_flag)
      else $error("reset flag dropped without a clear");
   wrf_clear_a: assert property (CTRL_WR.wr && CTRL_WR.clr_wrf && !(tmo_hit && rst_en_q) |=> !wrf_flag)
      else $error("reset flag not cleared");
   // With the reset disabled a timeout must not mark a watchdog reset.
   no_wrf_a: assert property (!rst_en_q && !wrf_flag |=> !wrf_flag)
      else $error("reset flag set while reset disabled");

   // The interrupt line follows flag and enable, and a reset pulse only starts at a timeout.
   irq_out_a: assert property (irq_flag && irq_en_q |-> CTRL_RD.irq)
      else $error("enabled interrupt not raised");
   rst_start_a: assert property (CTRL_RD.sys_reset |-> $past(CTRL_RD.sys_reset) || ($past(tmo_hit) && $past(rst_en_q)))
      else $error("reset pulse without a timeout");

   // Control fields follow each write and hold between writes.
   irq_en_write_a: assert property (CTRL_WR.wr |=> irq_en_q == $past(CTRL_WR.irq_en))
      else $error("interrupt enable not written");
   rst_en_write_a: assert property (CTRL_WR.wr |=> rst_en_q == $past(CTRL_WR.rst_en))
      else $error("reset enable not written");
   sel_hold_a: assert property (!CTRL_WR.wr |=> $stable(sel_q))
      else $error("select changed without a write");
   irq_en_hold_a: assert property (!CTRL_WR.wr |=> $stable(irq_en_q))
      else $error("interrupt enable changed without a write");
   rst_en_hold_a: assert property (!CTRL_WR.wr |=> $stable(rst_en_q))
      else $error("reset enable changed without a write");

endmodule // software_watchdog_timer

// file: verilog/wdt_pkg.sv
// Package with constants and carrier types for the software watchdog timer.
package wdt_pkg;

   // Interval select codes and the matching counter bit widths.
   localparam logic [1:0]  SEL_2P12      = 2'h0;
   localparam logic [1:0]  SEL_2P15      = 2'h1;
   localparam logic [1:0]  SEL_2P18      = 2'h2;
   localparam logic [1:0]  SEL_2P21      = 2'h3;
   localparam int          EXP_2P12      = 12;
   localparam int          EXP_2P15      = 15;
   localparam int          EXP_2P18      = 18;
   localparam int          EXP_2P21      = 21;
   localparam int          CNT_W         = 22;
   // Early warning lead in system clocks.
   localparam int          WARN_LEAD     = 512;
   // Program restart location after a watchdog reset.
   localparam logic [15:0] RESET_VECTOR  = 16'h8000;
   // Control register field positions.
   localparam int          BIT_RESTART   = 0;
   localparam int          BIT_RST_EN    = 1;
   localparam int          BIT_IRQ_FLAG  = 2;
   localparam int          BIT_IRQ_EN    = 3;
   localparam int          BIT_WRF       = 4;
   localparam int          POS_SEL       = 5;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam int          RST_PULSE_LEN = 4;

   // Software write to the control register.
   typedef struct packed {
      logic       wr;
      logic [1:0] sel;
      logic       irq_en;
      logic       rst_en;
      logic       restart;
      logic       clr_irq;
      logic       clr_wrf;
   } ctrl_wr_t;

   // State shown back to software.
   typedef struct packed {
      logic [7:0] reg_value;
      logic       irq;
      logic       sys_reset;
   } ctrl_rd_t;

endpackage

// file: verilog/wdt_stage.sv
// Sticky flag stage shared by the interrupt flag and the watchdog reset flag.
module wdt_stage
   import wdt_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic RESET,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag_q
);

   logic flag_d;

   // Set wins over a clear in the same cycle, so no event is lost.
   always_comb begin
      flag_d = flag_q;
      if (clr) begin
         flag_d = 1'b0;
      end
      if (set) begin
         flag_d = 1'b1;
      end
   end

   // Register the flag.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule // wdt_stage
